// *** rtl/t1_alarm_defs.vh ***
// Offsets, field positions, reset values and timing for the T1 receive alarm monitor
`ifndef T1_ALARM_DEFS_VH
`define T1_ALARM_DEFS_VH

// ****************************************
// Register offsets (framer one)
// ****************************************
`define OFF_LIVE_ONE     12'h0b0
`define OFF_STICKY_ONE   12'h090
`define OFF_MASK_ONE     12'h0a0
`define OFF_RX_CTRL_TWO  12'h004
`define FRAMER_STRIDE    12'h200

// ****************************************
// Live status field positions
// ****************************************
`define LIVE_LOF   0
`define LIVE_LOS   1
`define LIVE_AIS   2
`define LIVE_RAI   3
// Sticky: rising edge at live position, falling edge at live position plus 4
`define STICKY_FALL_OFS 4

// ****************************************
// Control fields and reset values
// ****************************************
`define CTL_YEL_FBIT   0
`define CTL_ESF        2
`define RST_MASK       8'h00
`define RST_CTRL       8'h00

// ****************************************
// Alarm criteria
// ****************************************
`define AIS_WIN_US      3000
`define CLK_MHZ         10
`define AIS_MAX_ZEROS   4
`define RAI_CHANS       256
`define RAI_MIN_ZEROS   254
`define ESF_PATTERN     16'h00ff
`define ESF_RUN         16
`define ESF_KEEP_MIN    15
`define LOS_ZEROS       192
`define LOS_WIN_BITS    112
`define LOS_MIN_ONES    14

`endif

// *** rtl/t1_alarm_status_monitor.v ***
// Receive alarm detectors, live and sticky status, mask and interrupt for one T1 framer
//
// Overview of operation
// (R1) Sticky bit holds one until host clears
// (R2) Write one clears sticky, zero keeps
// (R3) Cleared bit resets only on new event
// (R4) Live bits read-only, show present state
// (R5) Live reads never touch sticky bits
// (R6) Read value stable through the access
// (R7) Mask bits gate sticky bits onto interrupt
// (R8) Unmasked sticky bit drives interrupt low
// (R9) Interrupt high once causes are cleared
// (R10) Clear releases bit despite ongoing alarm
// (R11) Live bit zero shows frame loss
// (R12) Sticky bit zero on frame loss
// (R13) Sticky bit four on frame regain
// (R14) Blue alarm on four zeros per 3ms
// (R15) Blue alarm clears on five zeros
// (R16) Bit-two mode: 254 of 256 zero
// (R17) Twelfth F-bit: two equal bits decide
// (R18) ESF: sixteen consecutive 00ff sets yellow
// (R19) ESF: fourteen or fewer of sixteen clear
// (R20) Carrier loss after 192 zeros
// (R21) Carrier back: 14 ones in 112 bits
// (R22) Framer n at base plus (n-1)*200h
// (R23) Blue alarm robust, ignores framed ones
// (R24) Event wins over same-cycle clear
`timescale 1ns/1ps
`default_nettype none
`include "t1_alarm_defs.vh"

module t1_alarm_status_monitor #(
  parameter [3:0]  FRAMER_NUM  = 4'd1,
  parameter        AIS_WIN_CYC = `AIS_WIN_US * `CLK_MHZ
) (
  input  wire        mclk_in,
  input  wire        nrst_in,
  input  wire [11:0] addr_in,
  input  wire [7:0]  wr_data_in,
  input  wire        wr_en_in,
  input  wire        rd_en_in,
  output reg  [7:0]  rd_data_out,
  input  wire        rx_data_in,
  input  wire        rx_bit_en_in,
  input  wire        chan_bit2_en_in,
  input  wire        fbit12_en_in,
  input  wire        fdl_bit_en_in,
  input  wire        rx_frame_loss_in,
  output reg         irq_out_n
);

  // ****************************************
  // Address decode
  // ****************************************
  localparam [11:0] BASE = (FRAMER_NUM - 4'd1) * `FRAMER_STRIDE; // R22

  function hit;
    input [11:0] a;
    input [11:0] off;
    begin
      hit = (a == BASE + off); // R22
    end
  endfunction

  // Saturating count: a long run must not wrap back under its threshold
  function [8:0] sat_inc;
    input [8:0] v;
    input [8:0] lim;
    begin
      if (v == lim)
        sat_inc = v;
      else
        sat_inc = v + 9'h001;
    end
  endfunction

  wire sel_live   = hit(addr_in, `OFF_LIVE_ONE);
  wire sel_sticky = hit(addr_in, `OFF_STICKY_ONE);
  wire sel_mask   = hit(addr_in, `OFF_MASK_ONE);
  wire sel_ctrl   = hit(addr_in, `OFF_RX_CTRL_TWO);

  reg  [7:0] rx_sticky_status_one_q;
  reg  [7:0] rx_sticky_status_one_d;
  reg  [7:0] rx_irq_mask_set_q;
  reg  [7:0] t1_rx_control_two_q;
  reg  [3:0] live_q;
  reg  [3:0] live_prev_q;

  wire yel_fbit = t1_rx_control_two_q[`CTL_YEL_FBIT];
  wire esf_mode = t1_rx_control_two_q[`CTL_ESF];

  // ****************************************
  // Blue alarm: zeros counted per fixed window
  // ****************************************
  reg [31:0] ais_tmr_q;
  reg [2:0]  ais_zero_q;
  reg        ais_q;
  wire       ais_end = (ais_tmr_q == AIS_WIN_CYC - 1);
  wire       ais_zero_bit = rx_bit_en_in && !rx_data_in;
  wire [8:0] ais_zero_inc = sat_inc({6'h00, ais_zero_q}, 9'h005);

  // Unframed ones carry no zeros, framed ones carry F-bit zeros well over four
  // per window, and a 10E-3 error rate adds about five errors per window,
  // mostly ones-to-zeros only on a zero-rich line, so the threshold holds.
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ais_tmr_q  <= 32'h0000_0000;
      ais_zero_q <= 3'h0;
      ais_q      <= 1'b0;
    end else begin
      if (ais_end) begin
        ais_tmr_q  <= 32'h0000_0000;
        // The closing bit was judged above; counting it again would double it
        ais_zero_q <= 3'h0;
        ais_q      <= ({1'b0, ais_zero_q} + {3'b000, ais_zero_bit})
                      <= `AIS_MAX_ZEROS; // R14 R15 R23
      end else begin
        ais_tmr_q <= ais_tmr_q + 32'h0000_0001;
        if (ais_zero_bit)
          ais_zero_q <= ais_zero_inc[2:0];
      end
    end
  end

  // ****************************************
  // Yellow alarm, D4 bit-two mode
  // ****************************************
  // Channels are judged in back-to-back blocks of 256; a sliding count would
  // need the whole 256-bit history kept
  reg [7:0] b2_chan_q;
  reg [8:0] b2_zero_q;
  reg       b2_rai_q;
  wire [8:0] b2_zero_now = b2_zero_q + {8'h00, !rx_data_in};

  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      b2_chan_q <= 8'h00;
      b2_zero_q <= 9'h000;
      b2_rai_q  <= 1'b0;
    end else if (chan_bit2_en_in) begin
      b2_chan_q <= b2_chan_q + 8'h01;
      if (b2_chan_q == `RAI_CHANS - 1) begin
        b2_zero_q <= 9'h000;
        b2_rai_q  <= (b2_zero_now >= `RAI_MIN_ZEROS); // R16
      end else begin
        b2_zero_q <= b2_zero_now;
      end
    end
  end

  // ****************************************
  // Yellow alarm, D4 twelfth F-bit mode
  // ****************************************
  reg f12_last_q;
  reg f12_rai_q;

  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      f12_last_q <= 1'b0;
      f12_rai_q  <= 1'b0;
    end else if (fbit12_en_in) begin
      f12_last_q <= rx_data_in;
      if (f12_last_q == rx_data_in)
        f12_rai_q <= rx_data_in; // R17
    end
  end

  // ****************************************
  // Yellow alarm, ESF data link
  // ****************************************
  // Patterns are framed on the first sliding match; afterwards each 16-bit
  // slot is judged as a whole, so the window is 16 patterns, not 256 bits.
  reg [15:0] fdl_sh_q;
  reg [3:0]  fdl_ph_q;
  reg        fdl_lock_q;
  reg [4:0]  esf_run_q;
  reg [3:0]  esf_slot_q;
  reg [4:0]  esf_hit_q;
  reg        esf_rai_q;
  wire [15:0] fdl_sh_d = {fdl_sh_q[14:0], rx_data_in};
  wire        fdl_match = (fdl_sh_d == `ESF_PATTERN);
  wire        fdl_slot  = fdl_lock_q && fdl_ph_q == 4'hf;
  wire [4:0]  esf_hit_now = esf_hit_q + {4'h0, fdl_match};
  wire [8:0]  esf_run_inc = sat_inc({4'h0, esf_run_q}, 9'h010);

  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fdl_sh_q   <= 16'h0000;
      fdl_ph_q   <= 4'h0;
      fdl_lock_q <= 1'b0;
      esf_run_q  <= 5'h00;
      esf_slot_q <= 4'h0;
      esf_hit_q  <= 5'h00;
      esf_rai_q  <= 1'b0;
    end else if (!esf_mode) begin
      fdl_lock_q <= 1'b0;
      esf_run_q  <= 5'h00;
      esf_slot_q <= 4'h0;
      esf_hit_q  <= 5'h00;
      esf_rai_q  <= 1'b0;
    end else if (fdl_bit_en_in) begin
      fdl_sh_q <= fdl_sh_d;
      fdl_ph_q <= fdl_ph_q + 4'h1;
      if (!fdl_lock_q && fdl_match) begin
        fdl_lock_q <= 1'b1;
        fdl_ph_q   <= 4'h0;
        esf_run_q  <= 5'h01;
        esf_slot_q <= 4'h1;
        esf_hit_q  <= 5'h01;
      end else if (fdl_slot) begin
        esf_run_q  <= fdl_match ? esf_run_inc[4:0] : 5'h00;
        esf_slot_q <= esf_slot_q + 4'h1;
        if (fdl_match && esf_run_q == `ESF_RUN - 1)
          esf_rai_q <= 1'b1; // R18
        if (esf_slot_q == 4'hf) begin
          esf_hit_q <= 5'h00;
          if (esf_hit_now < `ESF_KEEP_MIN)
            esf_rai_q <= 1'b0; // R19
        end else begin
          esf_hit_q <= esf_hit_now;
        end
      end
    end
  end

  wire rai_now = esf_mode ? esf_rai_q : (yel_fbit ? f12_rai_q : b2_rai_q); // R16 R17

  // ****************************************
  // Loss of signal
  // ****************************************
  // One-hot: line good, lost and waiting for a one, lost with a window open
  localparam [2:0] LOS_GOOD = 3'b001;
  localparam [2:0] LOS_WAIT = 3'b010;
  localparam [2:0] LOS_WIN  = 3'b100;

  reg [2:0] los_st_q;
  reg [7:0] los_zero_q;
  reg [6:0] los_win_q;
  reg [3:0] los_ones_q;
  reg       rx_carrier_loss_q;

  wire [8:0] los_zero_inc = sat_inc({1'b0, los_zero_q}, 9'h0c0);

  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      los_st_q          <= LOS_GOOD;
      los_zero_q        <= 8'h00;
      los_win_q         <= 7'h00;
      los_ones_q        <= 4'h0;
      rx_carrier_loss_q <= 1'b0;
    end else if (rx_bit_en_in) begin
      if (rx_data_in)
        los_zero_q <= 8'h00;
      else
        los_zero_q <= los_zero_inc[7:0];
      case (los_st_q)
        LOS_GOOD: begin
          if (!rx_data_in && los_zero_q == `LOS_ZEROS - 1) begin
            los_st_q          <= LOS_WAIT;
            rx_carrier_loss_q <= 1'b1; // R20
          end
        end
        LOS_WAIT: begin
          // A window always starts at a one; a failed window waits here again
          if (rx_data_in) begin
            los_st_q   <= LOS_WIN;
            los_win_q  <= 7'h01;
            los_ones_q <= 4'h1;
          end
        end
        LOS_WIN: begin
          los_win_q  <= los_win_q + 7'h01;
          los_ones_q <= los_ones_q + {3'h0, rx_data_in};
          if (rx_data_in && los_ones_q == `LOS_MIN_ONES - 1) begin
            los_st_q          <= LOS_GOOD;
            rx_carrier_loss_q <= 1'b0; // R21
          end else if (los_win_q == `LOS_WIN_BITS - 1) begin
            los_st_q <= LOS_WAIT;
          end
        end
        default: begin
          los_st_q          <= LOS_GOOD;
          rx_carrier_loss_q <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // Live status, sticky status and interrupt
  // ****************************************
  wire [3:0] live_d;
  assign live_d[`LIVE_LOF] = rx_frame_loss_in; // R11
  assign live_d[`LIVE_LOS] = rx_carrier_loss_q;
  assign live_d[`LIVE_AIS] = ais_q;
  assign live_d[`LIVE_RAI] = rai_now;

  wire [7:0] edge_set = {live_prev_q & ~live_q, live_q & ~live_prev_q}; // R12 R13
  wire [7:0] clr_mask = (wr_en_in && sel_sticky) ? wr_data_in : 8'h00; // R2 R5

  always @* begin
    // Set wins over a same-cycle clear; with no edge nothing re-sets
    rx_sticky_status_one_d = (rx_sticky_status_one_q & ~clr_mask) | edge_set; // R1 R3 R10 R24
  end

  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      live_q                 <= 4'h0;
      live_prev_q            <= 4'h0;
      rx_sticky_status_one_q <= 8'h00;
      rx_irq_mask_set_q      <= `RST_MASK;
      t1_rx_control_two_q    <= `RST_CTRL;
      irq_out_n              <= 1'b1;
      rd_data_out            <= 8'h00;
    end else begin
      live_q                 <= live_d; // R4
      live_prev_q            <= live_q;
      rx_sticky_status_one_q <= rx_sticky_status_one_d;
      if (wr_en_in && sel_mask)
        rx_irq_mask_set_q <= wr_data_in;
      if (wr_en_in && sel_ctrl)
        t1_rx_control_two_q <= wr_data_in;
      // Mask bit one lets the sticky bit through
      irq_out_n <= ~|(rx_sticky_status_one_d & rx_irq_mask_set_q); // R7 R8 R9 R10
      // Captured once per read, so the value cannot move during the access
      if (rd_en_in) begin
        if (sel_live)
          rd_data_out <= {4'h0, live_q}; // R4 R5 R6
        else if (sel_sticky)
          rd_data_out <= rx_sticky_status_one_q;
        else if (sel_mask)
          rd_data_out <= rx_irq_mask_set_q;
        else if (sel_ctrl)
          rd_data_out <= t1_rx_control_two_q;
        else
          rd_data_out <= 8'h00;
      end else begin
        rd_data_out <= 8'h00;
      end
    end
  end

endmodule // t1_alarm_status_monitor

`default_nettype wire

// *** tb/t1_alarm_status_monitor_asserts.sv ***
// Port checker for the T1 receive alarm monitor
`timescale 1ns/1ps
`default_nettype none
`include "t1_alarm_defs.vh"
module t1_alarm_checker (
  input wire logic        mclk_in,
  input wire logic        nrst_in,
  input wire logic [11:0] addr_in,
  input wire logic [7:0]  wr_data_in,
  input wire logic        wr_en_in,
  input wire logic        rd_en_in,
  input wire logic [7:0]  rd_data_out,
  input wire logic        rx_frame_loss_in,
  input wire logic        irq_out_n
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  logic [7:0] mask_q;
  // Shadow of the mask register, so irq checks know which causes may pull it low
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) mask_q <= 8'h00;
    else if (wr_en_in && addr_in == `OFF_MASK_ONE) mask_q <= wr_data_in;
  end
  property p_rd_idle; !$past(rd_en_in) |-> rd_data_out == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_unmapped;
    rd_en_in && !(addr_in inside {`OFF_LIVE_ONE, `OFF_STICKY_ONE, `OFF_MASK_ONE,
      `OFF_RX_CTRL_TWO}) |=> rd_data_out == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_live_lof;
    rd_en_in && addr_in == `OFF_LIVE_ONE |=> rd_data_out[0] == $past(rx_frame_loss_in, 2);
  endproperty
  a_live_lof: assert property (p_live_lof) else $error("live frame loss wrong");
  property p_lof_irq; $rose(rx_frame_loss_in) && mask_q[0] |-> ##2 !irq_out_n; endproperty
  a_lof_irq: assert property (p_lof_irq) else $error("no irq on frame loss");
  property p_regain_irq; $fell(rx_frame_loss_in) && mask_q[4] |-> ##2 !irq_out_n; endproperty
  a_regain_irq: assert property (p_regain_irq) else $error("no irq on regain");
  property p_masked; $past(mask_q) == 8'h00 |-> irq_out_n; endproperty
  a_masked: assert property (p_masked) else $error("irq while all masked");
  property p_irq_rel; $rose(irq_out_n) |-> $past(wr_en_in) || $past(wr_en_in, 2); endproperty
  a_irq_rel: assert property (p_irq_rel) else $error("irq released without write");
  property p_clear;
    wr_en_in && addr_in == `OFF_STICKY_ONE && wr_data_in == 8'hff && mask_q == 8'h11
      && $stable(rx_frame_loss_in) && $past(rx_frame_loss_in) == $past(rx_frame_loss_in, 2)
      |=> irq_out_n;
  endproperty
  a_clear: assert property (p_clear) else $error("clear kept irq low");
endmodule // t1_alarm_checker
bind t1_alarm_status_monitor t1_alarm_checker u_chk (.mclk_in(mclk_in), .nrst_in(nrst_in),
  .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
  .rd_data_out(rd_data_out), .rx_frame_loss_in(rx_frame_loss_in), .irq_out_n(irq_out_n));
`default_nettype wire

// *** tb/t1_line_model.sv ***
// Incoming T1 line: one bit per request on one of four qualifier lanes
`timescale 1ns/1ps
`default_nettype none
module t1_line_model (
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  input  wire logic       go_in,
  input  wire logic [1:0] lane_in,
  input  wire logic       val_in,
  output var  logic       data_out,
  output var  logic [3:0] en_out
);
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      data_out <= 1'b0;
      en_out <= 4'h0;
    end else begin
      en_out <= go_in ? (4'h1 << lane_in) : 4'h0;
      // Unqualified cycles toggle so a stale bit is never mistaken for data
      data_out <= go_in ? val_in : ~data_out;
    end
  end
endmodule // t1_line_model
`default_nettype wire

// *** tb/t1_alarm_status_monitor_test.sv ***
// Self-checking bench for the T1 receive alarm monitor
`timescale 1ns/1ps
`default_nettype none
`include "t1_alarm_defs.vh"
module t1_alarm_status_monitor_test;
  // ****************************************
  // Signals, model and design
  // ****************************************
  localparam int WIN = 200;
  logic mclk_in = 1'b0;
  logic nrst_in;
  logic [11:0] addr_in = 12'h000;
  logic [7:0] wr_data_in = 8'h00;
  logic wr_en_in = 1'b0, rd_en_in = 1'b0, rx_frame_loss_in = 1'b0;
  logic go = 1'b0, val = 1'b0, rd_pend = 1'b0, rx_data, irq_out_n;
  logic [1:0] lane = 2'h0;
  logic [3:0] en;
  logic [7:0] rd_data_out;
  logic [15:0] expq[$], x;
  int failures = 0, comparisons = 0;
  t1_line_model u_line (.clk_in(mclk_in), .nrst_in(nrst_in), .go_in(go), .lane_in(lane),
    .val_in(val), .data_out(rx_data), .en_out(en));
  t1_alarm_status_monitor #(.FRAMER_NUM(4'h1), .AIS_WIN_CYC(WIN)) u_dut (.mclk_in(mclk_in),
    .nrst_in(nrst_in), .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in),
    .rd_en_in(rd_en_in), .rd_data_out(rd_data_out), .rx_data_in(rx_data),
    .rx_bit_en_in(en[0]), .chan_bit2_en_in(en[1]), .fbit12_en_in(en[2]),
    .fdl_bit_en_in(en[3]), .rx_frame_loss_in(rx_frame_loss_in), .irq_out_n(irq_out_n));
  initial forever #50 mclk_in = ~mclk_in;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    addr_in <= a; wr_data_in <= d; wr_en_in <= 1'b1;
    @(posedge mclk_in);
    wr_en_in <= 1'b0;
  endtask
  // Expected value is noted with the bits that matter; alarm timers run meanwhile
  task automatic rd(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge mclk_in);
    expq.push_back({m, e}); addr_in <= a; rd_en_in <= 1'b1;
    @(posedge mclk_in);
    rd_en_in <= 1'b0;
  endtask
  task automatic send(input logic [1:0] l, input logic v, input int n);
    repeat (n) begin
      @(posedge mclk_in);
      go <= 1'b1; lane <= l; val <= v;
    end
    @(posedge mclk_in);
    go <= 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  task automatic fdl(input int n, input bit brk);
    for (int i = 0; i < n; i++)
      for (int k = 0; k < 16; k++) send(2'h3, (k >= 8) ^ (brk && i % 4 == 0 && k == 0), 1);
  endtask
  always @(posedge mclk_in) begin
    rd_pend <= rd_en_in;
    if (rd_pend) begin
      x = expq.pop_front();
      chk(rd_data_out & x[15:8], x[7:0]);
    end
  end
  initial begin
    #(100 * 8000);
    failures++;
    test_done;
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    nrst_in = 1'b0;
    void'($urandom(57027));
    idle(2);
    nrst_in <= 1'b1;
    rd(`OFF_LIVE_ONE, 8'hff, 8'h00);
    rd(`OFF_STICKY_ONE, 8'hff, 8'h00);
    rd(`OFF_MASK_ONE, 8'hff, `RST_MASK);
    rd(`OFF_RX_CTRL_TWO, 8'hff, `RST_CTRL);
    chk(irq_out_n, 1'b1);
    rd(12'h400 + 12'($urandom_range(255)), 8'hff, 8'h00);
    wr(`OFF_LIVE_ONE, 8'hff);
    rd(`OFF_LIVE_ONE, 8'h01, 8'h00);
    $display("reset and decode test done");
    wr(`OFF_MASK_ONE, 8'h11);
    rx_frame_loss_in <= 1'b1;
    idle(3);
    chk(irq_out_n, 1'b0);
    rd(`OFF_LIVE_ONE, 8'h01, 8'h01);
    rd(`OFF_STICKY_ONE, 8'h11, 8'h01);
    wr(`OFF_STICKY_ONE, 8'h01);
    idle(1);
    chk(irq_out_n, 1'b1);
    rd(`OFF_STICKY_ONE, 8'h11, 8'h00);
    rx_frame_loss_in <= 1'b0;
    idle(3);
    chk(irq_out_n, 1'b0);
    rd(`OFF_STICKY_ONE, 8'h11, 8'h10);
    wr(`OFF_STICKY_ONE, 8'hff);
    idle(1);
    chk(irq_out_n, 1'b1);
    wr(`OFF_MASK_ONE, 8'h00);
    rx_frame_loss_in <= 1'b1;
    idle(3);
    chk(irq_out_n, 1'b1);
    rx_frame_loss_in <= 1'b0;
    wr(`OFF_STICKY_ONE, 8'h10);
    rd(`OFF_STICKY_ONE, 8'h10, 8'h10);
    $display("status and interrupt test done");
    idle(2 * WIN + 10);
    rd(`OFF_LIVE_ONE, 8'h04, 8'h04);
    send(2'h0, 1'b0, 191);
    idle(2);
    rd(`OFF_LIVE_ONE, 8'h02, 8'h00);
    send(2'h0, 1'b0, 1);
    idle(WIN + 10);
    rd(`OFF_LIVE_ONE, 8'h06, 8'h02);
    send(2'h0, 1'b1, 13);
    idle(3);
    rd(`OFF_LIVE_ONE, 8'h02, 8'h02);
    send(2'h0, 1'b1, 1);
    idle(3);
    rd(`OFF_LIVE_ONE, 8'h02, 8'h00);
    $display("blue and carrier test done");
    send(2'h1, 1'b0, 254);
    send(2'h1, 1'b1, 2);
    idle(3);
    rd(`OFF_LIVE_ONE, 8'h08, 8'h08);
    send(2'h1, 1'b0, 253);
    send(2'h1, 1'b1, 3);
    idle(3);
    rd(`OFF_LIVE_ONE, 8'h08, 8'h00);
    wr(`OFF_RX_CTRL_TWO, 8'h01);
    send(2'h2, 1'b1, 2);
    idle(3);
    rd(`OFF_LIVE_ONE, 8'h08, 8'h08);
    send(2'h2, 1'b0, 1);
    idle(3);
    rd(`OFF_LIVE_ONE, 8'h08, 8'h08);
    send(2'h2, 1'b0, 1);
    idle(3);
    rd(`OFF_LIVE_ONE, 8'h08, 8'h00);
    wr(`OFF_RX_CTRL_TWO, 8'h04);
    fdl(18, 1'b0);
    idle(3);
    rd(`OFF_LIVE_ONE, 8'h08, 8'h08);
    fdl(36, 1'b1);
    idle(3);
    rd(`OFF_LIVE_ONE, 8'h08, 8'h00);
    $display("yellow alarm test done");
    idle(3);
    test_done;
  end
endmodule // t1_alarm_status_monitor_test
`default_nettype wire
